// [hdl/utopia_cell_port.sv]
// cell port device end with its receive buffer
// assumes the far end drives the link clock and launches on its rise
`timescale 1ns/100ps

// ------------------------------------------------------------------
// receive buffer
// ------------------------------------------------------------------
module utopia_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] fill
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;

  // occupancy from pointers with one wrap bit
  assign fill = wp_q - rp_q;
  assign in_ready = fill != (AW+1)'(DEPTH);
  assign out_valid = fill != '0;
  assign out_data = mem_q[rp_q[AW-1:0]];
  wire do_push = in_valid & in_ready & ce;
  wire do_pop = out_valid & out_ready & ce;

  // storage written without reset
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_q[wp_q[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (do_push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (do_pop) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule : utopia_fifo

// ------------------------------------------------------------------
// device end
// ------------------------------------------------------------------
module utopia_cell_port (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic ms_strap,
  input wire logic par_chk_en,
  input wire logic status_clr,
  utopia_if.dev link,
  input wire logic [utopia_pkg::OCTET_W-1:0] tx_in_data,
  input wire logic tx_in_valid,
  output logic tx_in_ready,
  output logic [utopia_pkg::OCTET_W-1:0] rx_out_data,
  output logic rx_out_soc,
  output logic rx_out_valid,
  input wire logic rx_out_ready,
  output logic par_err,
  output logic rx_ovf,
  output logic slave_mode
);
  import utopia_pkg::*;
  localparam int SW = OCTET_W + 5;

  // ----------------------------------------------------------------
  // pin synchronisers and link edge detect
  // ----------------------------------------------------------------
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  logic lclk_q;
  logic ms1_q;
  logic ms2_q;
  wire [SW-1:0] pins = {link.link_clk, link.rx_data, link.rx_par,
                        link.rx_soc, link.rx_clav, link.tx_clav};

  // two stages on every pin, then one for edge detect
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_q <= '0;
      s2_q <= '0;
      lclk_q <= 1'b0;
      ms1_q <= 1'b0;
      ms2_q <= 1'b0;
    end else if (ce) begin
      s1_q <= pins;
      s2_q <= s1_q;
      lclk_q <= s2_q[SW-1];
      ms1_q <= ms_strap;
      ms2_q <= ms1_q;
    end
  end

  // synchronised pin views
  wire [OCTET_W-1:0] rxd_s = s2_q[SW-2 -: OCTET_W]; // bit 7 first
  wire rxpar_s = s2_q[3];
  wire rxsoc_s = s2_q[2];
  wire rxclav_s = s2_q[1];
  wire txclav_s = s2_q[0];
  wire tick = ce & s2_q[SW-1] & ~lclk_q;
  assign slave_mode = ms2_q; // strap high selects slave

  // ----------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------
  logic rx_enb_q;
  logic par_err_q;
  logic rx_ovf_q;
  logic f_in_ready;
  logic [$clog2(FIFO_DEPTH):0] fill;

  // octet valid: slave uses switch enable, master needs our enable
  wire rx_valid = slave_mode ? rxclav_s
                             : (rxclav_s & rx_enb_q);
  wire push = tick & rx_valid;
  wire par_bad = par_chk_en & ~(^{rxd_s, rxpar_s});
  // enable or space level from buffer fill
  wire space_ok = slave_mode ? (fill <= RX_SPACE_MAX_FILL)
                             : (fill <= RX_ENB_MAX_FILL);
  wire rx_enb_d = space_ok & f_in_ready;

  utopia_fifo #(
    .WIDTH(OCTET_W + 1),
    .DEPTH(FIFO_DEPTH)
  ) rx_buf (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .in_valid(push),
    .in_ready(f_in_ready),
    .in_data({rxsoc_s, rxd_s}), // start marker kept with octet
    .out_valid(rx_out_valid),
    .out_ready(rx_out_ready),
    .out_data({rx_out_soc, rx_out_data}),
    .fill(fill)
  );

  // enable driven once per link cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_enb_q <= 1'b0;
    end else if (tick) begin
      rx_enb_q <= rx_enb_d;
    end
  end

  // sticky status, a new event beats the clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      par_err_q <= 1'b0;
      rx_ovf_q <= 1'b0;
    end else if (ce) begin
      par_err_q <= (push & par_bad) | (par_err_q & ~status_clr);
      rx_ovf_q <= (push & ~f_in_ready) | (rx_ovf_q & ~status_clr);
    end
  end

  assign link.rx_enb = rx_enb_q;
  assign par_err = par_err_q;
  assign rx_ovf = rx_ovf_q;

  // ----------------------------------------------------------------
  // transmit path
  // ----------------------------------------------------------------
  cell_state_t tx_st_q;
  logic [5:0] oct_q;
  logic [OCTET_W-1:0] txd_q;
  logic txpar_q;
  logic txsoc_q;
  logic txenb_q;

  // send decision per link cycle
  wire in_cell = tx_st_q == CELL_BUSY;
  wire at_last = oct_q == LAST_OCTET;
  wire start_ok = txclav_s & tx_in_valid; // space seen with data
  wire keep_ok = slave_mode ? txclav_s : 1'b1; // master never breaks
  wire send = tick & (in_cell ? keep_ok : start_ok);
  wire [OCTET_W-1:0] txd_d = tx_in_valid ? tx_in_data : IDLE_OCTET;
  assign tx_in_ready = send;

  // cell sequencer, next cell may start on the following tick
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_st_q <= CELL_IDLE;
      oct_q <= '0;
    end else if (send) begin
      case (tx_st_q)
        CELL_IDLE: begin
          tx_st_q <= CELL_BUSY;
          oct_q <= 6'h01;
        end
        default: begin
          if (at_last) begin
            tx_st_q <= CELL_IDLE; // space rechecked here
            oct_q <= '0;
          end else begin
            oct_q <= oct_q + 6'h01;
          end
        end
      endcase
    end
  end

  // transmit pins, updated on link ticks only
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      txd_q <= IDLE_OCTET;
      txpar_q <= 1'b1;
      txsoc_q <= 1'b0;
      txenb_q <= 1'b0;
    end else if (tick) begin
      txenb_q <= send; // high with every sent octet, idle fill included
      txsoc_q <= send & ~in_cell;
      if (send) begin
        txd_q <= txd_d;
        txpar_q <= ~(^txd_d);
      end
    end
  end

  assign link.tx_data = txd_q;
  assign link.tx_par = txpar_q;
  assign link.tx_soc = txsoc_q;
  assign link.tx_enb = txenb_q;
endmodule : utopia_cell_port

// [hdl/utopia_pkg.sv]
// constants shared by both ends of the cell port link
// assumes both ends run on one 25 MHz system clock
package utopia_pkg;
  // ----------------------------------------------------------------
  // widths and cell layout
  // ----------------------------------------------------------------
  localparam int OCTET_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam logic [5:0] LAST_OCTET = 6'h34; // index of octet 53
  localparam logic [5:0] CELL_CNT = 6'h35; // 53 octets per cell
  localparam logic [5:0] CLAV_CHECK_CNT = 6'h2C; // 44th octet
  localparam logic [7:0] IDLE_OCTET = 8'h00;
  // ----------------------------------------------------------------
  // receive buffer thresholds
  // ----------------------------------------------------------------
  localparam logic [4:0] RX_ENB_MAX_FILL = 5'h0E; // keeps two free
  localparam logic [4:0] RX_SPACE_MAX_FILL = 5'h04;
  // ----------------------------------------------------------------
  // link clock made by the far end
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int LINK_PERIOD_NS = 320;
  localparam int LINK_DIV = LINK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [3:0] LINK_DIV_M1 = 4'(LINK_DIV - 1);
  localparam logic [3:0] LINK_HALF = 4'(LINK_DIV / 2);
  // ----------------------------------------------------------------
  // cell sequencer states
  // ----------------------------------------------------------------
  typedef enum logic {CELL_IDLE = 1'b0, CELL_BUSY = 1'b1} cell_state_t;
endpackage : utopia_pkg

// [hdl/utopia_if.sv]
// link wires between the cell port and its far end
// assumes pin names follow the master-mode meaning
`timescale 1ns/100ps
interface utopia_if;
  logic link_clk;
  logic [utopia_pkg::OCTET_W-1:0] rx_data;
  logic rx_par;
  logic rx_soc;
  logic rx_clav; // slave mode: switch transmit enable
  logic rx_enb; // slave mode: cell space available
  logic [utopia_pkg::OCTET_W-1:0] tx_data;
  logic tx_par;
  logic tx_soc;
  logic tx_clav; // slave mode: switch receive enable
  logic tx_enb; // slave mode: cell available
  modport dev (
    input link_clk, rx_data, rx_par, rx_soc, rx_clav, tx_clav,
    output rx_enb, tx_data, tx_par, tx_soc, tx_enb
  );
  modport far (
    output link_clk, rx_data, rx_par, rx_soc, rx_clav, tx_clav,
    input rx_enb, tx_data, tx_par, tx_soc, tx_enb
  );
endinterface : utopia_if

// [hdl/utopia_far_end.sv]
// far end of the cell port link: phy in master mode, switch in slave
// assumes it makes the link clock from clk by division
`timescale 1ns/100ps
module utopia_far_end (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic role_slave,
  utopia_if.far link,
  input wire logic [utopia_pkg::OCTET_W-1:0] src_data,
  input wire logic src_valid,
  output logic src_ready,
  input wire logic sink_space,
  output logic [utopia_pkg::OCTET_W-1:0] sink_data,
  output logic sink_soc,
  output logic sink_valid,
  output logic sink_par_err
);
  import utopia_pkg::*;
  localparam int SW = OCTET_W + 4;

  // ----------------------------------------------------------------
  // link clock divider and pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] cnt_q;
  logic lclk_q;
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  wire [3:0] cnt_d = (cnt_q == LINK_DIV_M1) ? 4'h0 : cnt_q + 4'h1;
  wire tick = ce & (cnt_q == LINK_DIV_M1); // rising link edge
  wire [SW-1:0] pins = {link.rx_enb, link.tx_data, link.tx_par,
                        link.tx_soc, link.tx_enb};

  // divider and two stages on every pin
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_q <= '0;
      lclk_q <= 1'b0;
      s1_q <= '0;
      s2_q <= '0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      lclk_q <= cnt_d < LINK_HALF;
      s1_q <= pins;
      s2_q <= s1_q;
    end
  end

  // synchronised device outputs
  wire enb_s = s2_q[SW-1];
  wire [OCTET_W-1:0] txd_s = s2_q[SW-2 -: OCTET_W];
  wire txpar_s = s2_q[2];
  wire txsoc_s = s2_q[1];
  wire txenb_s = s2_q[0];
  assign link.link_clk = lclk_q;

  // ----------------------------------------------------------------
  // sending cells to the device receive bus
  // ----------------------------------------------------------------
  logic [5:0] f_oct_q;
  logic [OCTET_W-1:0] rxd_q;
  logic rxpar_q;
  logic rxsoc_q;
  logic rxclav_q;
  wire f_mid = f_oct_q != 6'h00;
  // master: octet only after enable seen; slave: whole cell on space
  wire f_send = tick & src_valid
              & (role_slave ? (f_mid | enb_s) : enb_s);
  assign src_ready = f_send;

  // receive bus drive
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      f_oct_q <= '0;
      rxd_q <= IDLE_OCTET;
      rxpar_q <= 1'b1;
      rxsoc_q <= 1'b0;
      rxclav_q <= 1'b0;
    end else if (tick) begin
      rxclav_q <= role_slave ? f_send : src_valid;
      rxsoc_q <= f_send & ~f_mid;
      if (f_send) begin
        rxd_q <= src_data;
        rxpar_q <= ~(^src_data);
        f_oct_q <= (f_oct_q == LAST_OCTET) ? 6'h00 : f_oct_q + 6'h01;
      end
    end
  end

  assign link.rx_data = rxd_q;
  assign link.rx_par = rxpar_q;
  assign link.rx_soc = rxsoc_q;
  assign link.rx_clav = rxclav_q;

  // ----------------------------------------------------------------
  // taking cells from the device transmit bus
  // ----------------------------------------------------------------
  logic [5:0] r_oct_q;
  logic txclav_q;
  logic [OCTET_W-1:0] snk_d_q;
  logic snk_soc_q;
  logic snk_v_q;
  logic snk_pe_q;
  wire r_take = tick & txenb_s;
  // master: space may only change between cells or from the 44th octet on; slave: any tick
  wire clav_free = role_slave | (r_oct_q == 6'h00)
                 | (r_oct_q >= CLAV_CHECK_CNT);

  // octet count within the cell being received
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r_oct_q <= '0;
      txclav_q <= 1'b0;
    end else if (tick) begin
      if (clav_free) begin
        txclav_q <= sink_space;
      end
      if (r_take) begin
        r_oct_q <= txsoc_s ? 6'h01
                 : (r_oct_q == CELL_CNT) ? 6'h00 : r_oct_q + 6'h01;
      end
    end
  end

  // sink strobe, one clk cycle per octet
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      snk_d_q <= '0;
      snk_soc_q <= 1'b0;
      snk_v_q <= 1'b0;
      snk_pe_q <= 1'b0;
    end else if (ce) begin
      snk_v_q <= r_take;
      snk_pe_q <= r_take & ~(^{txd_s, txpar_s});
      if (r_take) begin
        snk_d_q <= txd_s;
        snk_soc_q <= txsoc_s;
      end
    end
  end

  assign link.tx_clav = txclav_q;
  assign sink_data = snk_d_q;
  assign sink_soc = snk_soc_q;
  assign sink_valid = snk_v_q;
  assign sink_par_err = snk_pe_q;
endmodule : utopia_far_end

// [tb/utopia_props.sv]
// checker on the link wires between the two ends
// assumes one clk domain; the link clock is sampled as data
`timescale 1ns/100ps
module utopia_props (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic slave_mode,
  input wire logic link_clk,
  input wire logic [7:0] rx_data,
  input wire logic rx_par,
  input wire logic rx_soc,
  input wire logic rx_clav,
  input wire logic rx_enb,
  input wire logic [7:0] tx_data,
  input wire logic tx_par,
  input wire logic tx_soc,
  input wire logic tx_clav,
  input wire logic tx_enb
);
  import utopia_pkg::*;
  // ----------------------------------------------------------------
  // link rise and octets since start of cell
  // ----------------------------------------------------------------
  logic lk_q;
  logic [5:0] oct_q;
  logic [5:0] oct_d;
  wire lr = link_clk & ~lk_q;
  // count only octets that carry enable
  assign oct_d = tx_soc ? 6'h01 : (oct_q == CELL_CNT) ? 6'h00 :
    (oct_q != 6'h00 && tx_enb) ? oct_q + 6'h01 : oct_q;
  // rise detector and octet counter
  always_ff @(posedge clk) begin
    lk_q <= link_clk;
    if (!rst_b) oct_q <= 6'h00;
    else if (lr) oct_q <= oct_d;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  chk_tx_par_odd: assert property (
    ^{tx_data, tx_par}) else $error("tx parity even");
  chk_rx_par_odd: assert property (
    ^{rx_data, rx_par}) else $error("rx parity even");
  chk_soc_has_enb: assert property (
    !slave_mode && tx_soc |-> tx_enb) else $error("soc without enable");
  chk_cell_unbroken: assert property (
    lr && !slave_mode && oct_q != 6'h00 && oct_q < CELL_CNT
    |-> tx_enb && !tx_soc) else $error("cell broken");
  chk_soc_spacing: assert property (
    lr && tx_soc && oct_q > 6'h01 |-> oct_q == CELL_CNT)
    else $error("soc inside cell");
  chk_rx_soc_clav: assert property (
    lr && rx_soc |-> rx_clav) else $error("rx soc without clav");
  chk_tx_stands: assert property (
    lr |-> $stable({tx_data, tx_par, tx_soc, tx_enb}))
    else $error("tx changed at link rise");
  chk_rx_enb_up: assert property (
    $rose(rst_b) |-> ##[1:40] rx_enb) else $error("rx enable stuck");
  cov_back_to_back: cover property (lr && tx_soc && oct_q == CELL_CNT);
  cov_rx_cell: cover property (lr && rx_soc && rx_clav);
  cov_slave_tx: cover property (lr && slave_mode && tx_enb);
endmodule : utopia_props

// [tb/tb_top.sv]
// self-checking bench for both ends of the cell port link
// assumes 25 MHz clk; far end makes the link clock
`timescale 1ns/100ps
module tb_top;
  import utopia_pkg::*;
  typedef struct packed {
    logic slave;
    logic [7:0] base;
    logic [7:0] step;
    logic [1:0] cells;
    logic stall;
  } row_t;
  localparam row_t rows [3] = '{'{1'b0, 8'h00, 8'h01, 2'h1, 1'b0},
    '{1'b0, 8'hFF, 8'h03, 2'h2, 1'b1}, '{1'b1, 8'h5A, 8'h07, 2'h2, 1'b0}};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ms_strap = 1'b0;
  logic par_chk_en = 1'b1;
  logic status_clr = 1'b0;
  logic [7:0] tx_in_data = 8'h00;
  logic tx_in_valid = 1'b0;
  logic rx_out_ready = 1'b0;
  logic [7:0] src_data = 8'h00;
  logic src_valid = 1'b0;
  logic sink_space = 1'b0;
  logic tx_in_ready, rx_out_soc, rx_out_valid, par_err, rx_ovf, slave_mode;
  logic src_ready, sink_soc, sink_valid, sink_par_err, par_err2;
  logic [7:0] rx_out_data, sink_data;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int tx_n, src_n, sink_n, out_n, lim;
  row_t cur;
  utopia_if utopia_if_i ();
  utopia_if fault_if ();
  utopia_cell_port utopia_cell_port_i (.clk(clk), .rst_b(rst_b), .ce(1'b1),
    .ms_strap(ms_strap), .par_chk_en(par_chk_en), .status_clr(status_clr),
    .link(utopia_if_i), .tx_in_data(tx_in_data), .tx_in_valid(tx_in_valid),
    .tx_in_ready(tx_in_ready), .rx_out_data(rx_out_data),
    .rx_out_soc(rx_out_soc), .rx_out_valid(rx_out_valid),
    .rx_out_ready(rx_out_ready), .par_err(par_err), .rx_ovf(rx_ovf),
    .slave_mode(slave_mode));
  utopia_far_end utopia_far_end_i (.clk(clk), .rst_b(rst_b), .ce(1'b1),
    .role_slave(ms_strap), .link(utopia_if_i), .src_data(src_data),
    .src_valid(src_valid), .src_ready(src_ready), .sink_space(sink_space),
    .sink_data(sink_data), .sink_soc(sink_soc), .sink_valid(sink_valid),
    .sink_par_err(sink_par_err));
  // second device end fed by a bench driver that breaks parity
  if (1) begin : fault_end
    utopia_cell_port utopia_cell_port_i (.clk(clk), .rst_b(rst_b),
      .ce(1'b1), .ms_strap(ms_strap), .par_chk_en(par_chk_en),
      .status_clr(status_clr), .link(fault_if), .tx_in_data(tx_in_data),
      .tx_in_valid(tx_in_valid), .tx_in_ready(), .rx_out_data(),
      .rx_out_soc(), .rx_out_valid(), .rx_out_ready(rx_out_ready),
      .par_err(par_err2), .rx_ovf(), .slave_mode());
  end
  utopia_props utopia_props_i (.clk(clk), .rst_b(rst_b),
    .slave_mode(slave_mode), .link_clk(utopia_if_i.link_clk),
    .rx_data(utopia_if_i.rx_data), .rx_par(utopia_if_i.rx_par),
    .rx_soc(utopia_if_i.rx_soc), .rx_clav(utopia_if_i.rx_clav),
    .rx_enb(utopia_if_i.rx_enb), .tx_data(utopia_if_i.tx_data),
    .tx_par(utopia_if_i.tx_par), .tx_soc(utopia_if_i.tx_soc),
    .tx_clav(utopia_if_i.tx_clav), .tx_enb(utopia_if_i.tx_enb));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] pat(input int i);
    pat = cur.base + 8'(i) * cur.step;
  endfunction : pat
  task automatic check(input bit ok, input string msg);
    samples_checked++;
    if (!ok) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  // one fault-side link cycle, parity flipped when bad is set
  task automatic put_octet(input logic [7:0] d, input logic bad);
    fault_if.rx_data <= d;
    fault_if.rx_par <= ~^d ^ bad;
    fault_if.rx_soc <= 1'b1;
    fault_if.rx_clav <= 1'b1;
    fault_if.link_clk <= 1'b1;
    repeat (4) @(posedge clk);
    fault_if.link_clk <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : put_octet
  task automatic run_row(input row_t r);
    int n;
    cur = r;
    lim = 53 * r.cells;
    ms_strap <= r.slave;
    rst_b <= 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    {tx_n, src_n, sink_n, out_n} <= '0;
    tx_in_data <= pat(0);
    src_data <= pat(0);
    repeat (4) @(posedge clk);
    check(slave_mode === r.slave, "mode strap");
    tx_in_valid <= 1'b1;
    src_valid <= 1'b1;
    sink_space <= !r.stall;
    rx_out_ready <= !r.stall;
    if (r.stall) begin
      repeat (1500) @(posedge clk);
      check(sink_n == 0 && rx_ovf === 1'b0, "stall");
      sink_space <= 1'b1;
      rx_out_ready <= 1'b1;
    end
    n = 0;
    while ((sink_n < lim || out_n < lim) && n < 5000) begin
      @(posedge clk);
      n++;
    end
    check(sink_n == lim && out_n == lim, "cell count");
  endtask : run_row
  // ----------------------------------------------------------------
  // clock, timeout and user-side drivers and monitors
  // ----------------------------------------------------------------
  initial forever #20 clk = ~clk;
  initial {fault_if.link_clk, fault_if.rx_clav, fault_if.tx_clav} = '0;
  initial {fault_if.rx_data, fault_if.rx_soc, fault_if.rx_par} = 10'h001;
  // cycle ceiling, reaching it counts as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      wrap_up;
    end
  end
  // next octet once the current one is taken
  always @(posedge clk) begin
    if (tx_in_valid && tx_in_ready) begin
      tx_n <= tx_n + 1;
      tx_in_data <= pat(tx_n + 1);
      tx_in_valid <= (tx_n + 1 < lim);
    end
    if (src_valid && src_ready) begin
      src_n <= src_n + 1;
      src_data <= pat(src_n + 1);
      src_valid <= (src_n + 1 < lim);
    end
  end
  // compare arrivals at both user sides
  always @(posedge clk) begin
    if (sink_valid === 1'b1) begin
      check(sink_data === pat(sink_n) && sink_par_err === 1'b0 &&
        sink_soc === (sink_n % 53 == 0), "far sink octet");
      sink_n <= sink_n + 1;
    end
    if (rx_out_valid === 1'b1 && rx_out_ready) begin
      check(rx_out_data === pat(out_n) && par_err === 1'b0 &&
        rx_out_soc === (out_n % 53 == 0), "device rx octet");
      out_n <= out_n + 1;
    end
  end
  // ----------------------------------------------------------------
  // main sequence: table rows, mid-cell reset, parity faults
  // ----------------------------------------------------------------
  initial begin
    for (int k = 0; k < 3; k++) begin
      run_row(rows[k]);
    end
    check(rx_ovf === 1'b0, "no overflow");
    ms_strap <= 1'b0;
    {tx_n, src_n, sink_n, out_n} <= '0;
    tx_in_data <= pat(0);
    src_data <= pat(0);
    tx_in_valid <= 1'b1;
    src_valid <= 1'b1;
    repeat (300) @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    tx_in_valid <= 1'b0;
    src_valid <= 1'b0;
    check({utopia_if_i.rx_enb, utopia_if_i.tx_enb, utopia_if_i.tx_soc,
      utopia_if_i.tx_par, utopia_if_i.tx_data, utopia_if_i.link_clk,
      rx_out_valid, sink_valid} === 15'h0800, "reset values");
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    repeat (3) put_octet(8'hA5, 1'b0);
    check(par_err2 === 1'b0, "good parity");
    put_octet(8'h3C, 1'b1);
    check(par_err2 === 1'b1, "bad parity flagged");
    status_clr <= 1'b1;
    @(posedge clk);
    status_clr <= 1'b0;
    repeat (2) @(posedge clk);
    check(par_err2 === 1'b0, "flag cleared");
    par_chk_en <= 1'b0;
    put_octet(8'h81, 1'b1);
    check(par_err2 === 1'b0, "check disabled");
    wrap_up;
  end
endmodule : tb_top
